// ### design/bttd_pkg.sv
// Package: constants and types of the touch button decision block
// Function
// - Bit 7: matrix-key (one key plus priority key) or first-single-touch reporting
// - Bit 6 makes last channel the priority key; ignored while bit 7 is set
// - Bits 5:4 pick touch/release interrupt events
// - Bits 3:2 set release debounce sample count
// - Bits 1:0 set touch debounce sample count
// - Count configured samples, one per scan
// - Touch count starts above threshold plus hysteresis
// - Release debounce code zero: first low tick releases
// - Shared hysteresis percent, 0..100, default ten
// - Ticks above suspend level stop averaging
// - Three channels at suspend level start compensation
// - Negative limit in fours, default 0xA0
// - Negative counter reaching limit starts compensation
// - Compensation fetches fresh idle reference values
// - Stuck timeout zero off, else seconds
// - Hysteresis scales each channel's own threshold
// - Stuck timeout compensates, releases, awaits real lift
// - Every channel uses its own threshold
package bttd_pkg;
   // Channel geometry
   localparam int NUM_CH = 12;
   localparam int TICK_W = 12;
   localparam logic [3:0] FIRST_CH = 4'h0;
   localparam logic [3:0] LAST_CH = 4'hb;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_THR0 = 6'h13;
   localparam logic [5:0] IDX_CFG = 6'h22;
   localparam logic [5:0] IDX_AVG = 6'h23;
   localparam logic [5:0] IDX_NEG = 6'h24;
   localparam logic [5:0] IDX_NCNT = 6'h25;
   localparam logic [5:0] IDX_HYST = 6'h26;
   localparam logic [5:0] IDX_STUCK = 6'h27;
   localparam logic [5:0] IDX_STATUS = 6'h28;
   // Reset values
   localparam logic [7:0] RST_CFG = 8'h30;
   localparam logic [7:0] RST_AVG = 8'h50;
   localparam logic [7:0] RST_NEG = 8'ha0;
   localparam logic [7:0] RST_NCNT = 8'h01;
   localparam logic [7:0] RST_HYST = 8'h0a;
   localparam logic [7:0] RST_STUCK = 8'h00;
   localparam logic [7:0] RST_THR = 8'h20;
   // Arithmetic limits
   localparam logic [7:0] HYST_MAX = 8'h64;
   localparam logic [16:0] PCT_DIV = 17'h0_0064;
   localparam logic [3:0] AVG_MIN_CH = 4'h3;
   // Timing: one second at the pclk rate
   localparam int SEC_NS = 1_000_000_000;
   localparam int CLK_NS = 5;
   localparam int SEC_CYCLES_DEF = SEC_NS / CLK_NS;
   // Fields of the report configuration register, msb first
   typedef struct packed {
      logic single_report;
      logic pk_en;
      logic [1:0] irq_sel;
      logic [1:0] rel_db;
      logic [1:0] touch_db;
   } bttd_cfg_type;
   // Signed tick of one channel and the set of all channels
   typedef logic signed [TICK_W-1:0] bttd_tick_type;
   typedef bttd_tick_type [NUM_CH-1:0] bttd_tick_vec_type;
   // Channel walk states
   typedef enum logic [1:0] {S_IDLE, S_READ, S_EVAL} bttd_state_type;
endpackage

// ### design/bttd_thr_mem.sv
// Threshold store: one word per channel, registered read port
`timescale 1ns/1ps
`default_nettype none
module bttd_thr_mem
   import bttd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [3:0] wr_addr,
   input wire logic [7:0] wr_data,
   input wire logic [3:0] rd_addr,
   output logic [7:0] rd_data
);
   logic [7:0] mem [NUM_CH]; // Threshold words

   // Write port with a defined reset value per word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_CH; i++) begin
            mem[i] <= RST_THR;
         end
      end else if (wr_en && (wr_addr <= LAST_CH)) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read data leave from a register, one cycle after the address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= 8'h00;
      end else begin
         rd_data <= (rd_addr <= LAST_CH) ? mem[rd_addr] : 8'h00;
      end
   end
endmodule
`default_nettype wire

// ### design/bttd_top.sv
// Touch and release decision for all sense channels, APB slave
`timescale 1ns/1ps
`default_nettype none
module bttd_top
   import bttd_pkg::*;
#(
   parameter int SEC_CYCLES = SEC_CYCLES_DEF // Clock cycles in one second
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scan_strobe,
   input wire bttd_tick_vec_type ticks,
   output logic [NUM_CH-1:0] touch_state,
   output logic [NUM_CH-1:0] avg_suspend,
   output logic comp_request,
   output logic event_irq_n
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////
   // Register file and APB decode

   logic [7:0] cfg_raw; // Report configuration
   logic [7:0] avg_thr; // Averaging suspend threshold
   logic [7:0] neg_thr; // Negative compensation threshold
   logic [7:0] neg_lim; // Negative count limit
   logic [7:0] hyst; // Hysteresis percent
   logic [7:0] stuck_to; // Stuck-touch timeout in seconds
   logic apb_stage; // Access phase has issued its memory read
   logic [7:0] mem_q; // Threshold read data
   bttd_state_type state; // Channel walk state
   logic [3:0] ch; // Channel under evaluation
   bttd_cfg_type cfg;

   assign cfg = bttd_cfg_type'(cfg_raw);

   // Address decoding
   wire [5:0] idx = paddr[7:2];
   wire thr_hit = (idx >= IDX_THR0) && (idx <= IDX_THR0 + 6'(LAST_CH));
   wire [3:0] thr_ch = 4'(idx - IDX_THR0);
   wire reg_hit = (idx >= IDX_CFG) && (idx <= IDX_STATUS);
   wire addr_ok = thr_hit || reg_hit;
   wire apb_acc = psel && penable && !pready;
   wire apb_done = psel && penable && pready;
   wire wr_fire = apb_done && pwrite && addr_ok && (idx != IDX_STATUS);
   wire status_rd = apb_done && !pwrite && (idx == IDX_STATUS);

   // Read selection, narrow data in the low bits
   wire [7:0] rd_byte =
      (idx == IDX_CFG) ? cfg_raw :
      (idx == IDX_AVG) ? avg_thr :
      (idx == IDX_NEG) ? neg_thr :
      (idx == IDX_NCNT) ? neg_lim :
      (idx == IDX_HYST) ? hyst :
      (idx == IDX_STUCK) ? stuck_to :
      thr_hit ? mem_q : 8'h00;
   wire [31:0] rd_word = (idx == IDX_STATUS) ? {20'h0_0000, touch_state} :
      {24'h00_0000, rd_byte};

   // Memory read port belongs to the walk unless it is idle
   wire [3:0] mem_raddr = (state == S_IDLE) ? thr_ch : ch;

   // Per-channel thresholds in their own store
   bttd_thr_mem u_thr (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_fire && thr_hit),
      .wr_addr(thr_ch),
      .wr_data(pwdata[7:0]),
      .rd_addr(mem_raddr),
      .rd_data(mem_q)
   );

   // APB answer: two wait cycles so threshold reads pass the store
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         apb_stage <= 1'b0;
      end else if (pready) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         apb_stage <= 1'b0;
      end else if (apb_acc && apb_stage) begin
         pready <= 1'b1;
         pslverr <= !addr_ok;
         prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end else if (apb_acc && (state == S_IDLE)) begin
         // A running walk owns the store; the bus waits for it
         apb_stage <= 1'b1;
      end
   end

   // Control registers take writes at the completing edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_raw <= RST_CFG;
         avg_thr <= RST_AVG;
         neg_thr <= RST_NEG;
         neg_lim <= RST_NCNT;
         hyst <= RST_HYST;
         stuck_to <= RST_STUCK;
      end else if (wr_fire) begin
         case (idx)
            IDX_CFG: cfg_raw <= pwdata[7:0];
            IDX_AVG: avg_thr <= pwdata[7:0];
            IDX_NEG: neg_thr <= pwdata[7:0];
            IDX_NCNT: neg_lim <= pwdata[7:0];
            IDX_HYST: hyst <= pwdata[7:0];
            IDX_STUCK: stuck_to <= pwdata[7:0];
            default: ; // Thresholds live in the store
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Scan capture, walk sequencer and second timebase

   bttd_tick_vec_type ticks_q; // Tick snapshot of the latest scan
   logic scan_pend; // Scan waiting for its walk
   logic [27:0] sec_cnt; // Cycle count within one second
   logic sec_seen; // A second elapsed since the last walk

   wire eval_en = (state == S_EVAL);
   wire walk_end = eval_en && (ch == LAST_CH);
   wire sec_wrap = (sec_cnt == 28'(SEC_CYCLES - 1));

   // Snapshot ticks so a walk sees one coherent scan
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ticks_q <= '0;
         scan_pend <= 1'b0;
      end else begin
         if (scan_strobe) begin
            ticks_q <= ticks;
         end
         // A new scan wins over the walk start that consumes the last
         scan_pend <= scan_strobe || (scan_pend && (state != S_IDLE));
      end
   end

   // One walk per scan, two cycles per channel
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= S_IDLE;
         ch <= FIRST_CH;
      end else begin
         case (state)
            S_IDLE: begin
               if (scan_pend) begin
                  state <= S_READ;
                  ch <= FIRST_CH;
               end
            end
            S_READ: state <= S_EVAL;
            S_EVAL: begin
               if (ch == LAST_CH) begin
                  state <= S_IDLE;
               end else begin
                  ch <= ch + 4'h1;
                  state <= S_READ;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // Seconds are folded into the next scan, so timers step per scan
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sec_cnt <= 28'h000_0000;
         sec_seen <= 1'b0;
      end else begin
         sec_cnt <= sec_wrap ? 28'h000_0000 : sec_cnt + 28'h000_0001;
         sec_seen <= sec_wrap || (sec_seen && !walk_end);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Decision arithmetic for the channel under evaluation

   logic touched [NUM_CH]; // Decided touch per channel
   logic locked [NUM_CH]; // Released by timeout, finger still down
   logic [1:0] db_cnt [NUM_CH]; // Debounce samples so far
   logic [7:0] stuck_t [NUM_CH]; // Seconds held touched
   logic [7:0] neg_cnt [NUM_CH]; // Consecutive negative scans

   wire cur_touch = touched[ch];
   wire cur_lock = locked[ch];
   wire [1:0] cur_db = db_cnt[ch];
   wire [7:0] cur_stuck = stuck_t[ch];
   wire [7:0] cur_neg = neg_cnt[ch];
   wire signed [12:0] tk = 13'(ticks_q[ch]);

   // Own threshold, scaled by four, with proportional hysteresis
   wire [9:0] thr4 = {mem_q, 2'b00};
   wire [6:0] hpct = (hyst > HYST_MAX) ? HYST_MAX[6:0] : hyst[6:0];
   wire [16:0] hprod = thr4 * hpct;
   wire [9:0] hamt = 10'(hprod / PCT_DIV);
   wire signed [12:0] on_lvl = $signed({3'b000, thr4}) + $signed({3'b000, hamt});
   wire signed [12:0] off_lvl = $signed({3'b000, thr4}) - $signed({3'b000, hamt});
   wire touch_cond = tk > on_lvl;
   wire rel_cond = tk < off_lvl;

   // Averaging suspend and negative compensation levels
   wire signed [12:0] avg_lvl = $signed({3'b000, avg_thr, 2'b00});
   wire signed [12:0] neg_lvl = 13'sh0 - $signed({3'b000, neg_thr, 2'b00});
   wire avg_cond = tk > avg_lvl;
   wire neg_cond = tk < neg_lvl;
   // Reserved zero behaves as one, the value hosts are advised to use
   wire [7:0] lim_eff = (neg_lim == 8'h00) ? 8'h01 : neg_lim;
   wire [7:0] neg_inc = (cur_neg == 8'hff) ? 8'hff : cur_neg + 8'h01;
   wire neg_fire = eval_en && neg_cond && (neg_inc >= lim_eff);
   wire [7:0] next_neg = (neg_cond && !neg_fire) ? neg_inc : 8'h00;

   // Debounce targets: code plus one samples
   wire [2:0] need_t = {1'b0, cfg.touch_db} + 3'h1;
   wire [2:0] need_r = {1'b0, cfg.rel_db} + 3'h1;
   wire [2:0] db_inc = {1'b0, cur_db} + 3'h1;

   // Reporting scheme and priority key gating
   wire pk_ch = cfg.pk_en && (ch == LAST_CH);
   wire [NUM_CH-1:0] pk_mask = {cfg.pk_en, 11'h000};
   wire mk_busy = |(touch_state & ~pk_mask);
   wire any_busy = |touch_state;
   wire allow = cfg.single_report ? !any_busy : (pk_ch || !mk_busy);
   wire stuck_hit = cur_touch && (stuck_to != 8'h00) && (cur_stuck >= stuck_to);

   logic next_touch; // Decision for this channel
   logic next_lock;
   logic [1:0] next_db;
   logic [7:0] next_stuck;
   logic ev_t; // Touch decided
   logic ev_r; // Release decided
   logic stuck_comp; // Timeout asks for compensation

   // Touch and release state step for the current channel
   always_comb begin
      next_touch = cur_touch;
      next_lock = cur_lock;
      next_db = 2'b00;
      next_stuck = cur_stuck;
      ev_t = 1'b0;
      ev_r = 1'b0;
      stuck_comp = 1'b0;
      if (cur_touch) begin
         if (stuck_hit) begin
            // Forced release; wait for a real lift before new touches
            next_touch = 1'b0;
            next_lock = 1'b1;
            next_stuck = 8'h00;
            ev_r = 1'b1;
            stuck_comp = 1'b1;
         end else if (rel_cond) begin
            if (db_inc >= need_r) begin
               next_touch = 1'b0;
               next_stuck = 8'h00;
               ev_r = 1'b1;
            end else begin
               next_db = db_inc[1:0];
            end
         end else if (sec_seen && (cur_stuck != 8'hff)) begin
            next_stuck = cur_stuck + 8'h01;
         end
      end else if (cur_lock) begin
         // Only a real release clears the lock
         next_lock = !rel_cond;
      end else if (touch_cond && allow) begin
         if (db_inc >= need_t) begin
            next_touch = 1'b1;
            next_stuck = 8'h00;
            ev_t = 1'b1;
         end else begin
            next_db = db_inc[1:0];
         end
      end
   end

   // Per-channel storage, written only while that channel is evaluated
   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      wire sel = eval_en && (ch == 4'(i));
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            touched[i] <= 1'b0;
            locked[i] <= 1'b0;
            db_cnt[i] <= 2'b00;
            stuck_t[i] <= 8'h00;
            neg_cnt[i] <= 8'h00;
            avg_suspend[i] <= 1'b0;
         end else if (sel) begin
            touched[i] <= next_touch;
            locked[i] <= next_lock;
            db_cnt[i] <= next_db;
            stuck_t[i] <= next_stuck;
            neg_cnt[i] <= next_neg;
            avg_suspend[i] <= avg_cond;
         end
      end
      assign touch_state[i] = touched[i];
   end

   ////////////////////////////////////////////////////////////////////////
   // Compensation request and interrupt line

   logic [3:0] avg_cnt; // Channels at suspend level in this walk
   logic comp_acc; // Compensation cause seen in this walk

   wire [3:0] next_avg = ((ch == FIRST_CH) ? 4'h0 : avg_cnt) + {3'b000, avg_cond};
   wire next_comp = ((ch == FIRST_CH) ? 1'b0 : comp_acc) || stuck_comp || neg_fire;
   wire irq_ev = (ev_t && cfg.irq_sel[0]) || (ev_r && cfg.irq_sel[1]);

   // One request pulse per walk fetches fresh idle references
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         avg_cnt <= 4'h0;
         comp_acc <= 1'b0;
         comp_request <= 1'b0;
      end else begin
         if (eval_en) begin
            avg_cnt <= next_avg;
            comp_acc <= next_comp;
         end
         comp_request <= walk_end && (next_comp || (next_avg >= AVG_MIN_CH));
      end
   end

   // Line held low until the status word is read; a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         event_irq_n <= 1'b1;
      end else if (eval_en && irq_ev) begin
         event_irq_n <= 1'b0;
      end else if (status_rd) begin
         event_irq_n <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Assertions

   sequence s_last_eval;
      eval_en && (ch == LAST_CH);
   endsequence

   sequence s_avg_burst;
      s_last_eval ##0 (next_avg >= AVG_MIN_CH);
   endsequence

   a_irq_on_touch: assert property (
      (eval_en && ev_t && cfg.irq_sel[0]) |=> !event_irq_n)
      else $error("touch event did not pull the interrupt line");
   a_irq_none_quiet: assert property (
      (event_irq_n && cfg.irq_sel == 2'b00 && !(psel && penable && pwrite)) |=> event_irq_n)
      else $error("interrupt line fell with reporting off");
   a_touch_db_count: assert property (
      (eval_en && ev_t) |-> (db_inc == need_t))
      else $error("touch decided at the wrong sample count");
   a_release_direct: assert property (
      (eval_en && cur_touch && rel_cond && cfg.rel_db == 2'b00) |=> !touched[$past(ch)])
      else $error("release not taken on the first low tick");
   a_single_block: assert property (
      (eval_en && cfg.single_report && any_busy) |-> !ev_t)
      else $error("second touch reported in single mode");
   a_mk_only_one: assert property (
      (eval_en && ev_t && !pk_ch) |-> !mk_busy)
      else $error("second matrix key touch reported");
   a_avg_comp_req: assert property (
      s_avg_burst |=> comp_request ##1 !comp_request)
      else $error("three suspended channels gave no single request");
   a_stuck_release: assert property (
      (eval_en && stuck_hit) |=> !touched[$past(ch)] && locked[$past(ch)] ##[0:22] comp_request)
      else $error("stuck timeout did not release and compensate");
   a_db_restart: assert property (
      (eval_en && !cur_touch && !cur_lock && !touch_cond) |=> db_cnt[$past(ch)] == 2'b00)
      else $error("touch debounce count survived a failed sample");
   a_neg_trigger: assert property (
      (eval_en && neg_cond && lim_eff == 8'h01 && ch != LAST_CH) |=> comp_acc)
      else $error("negative tick did not start compensation");
endmodule
`default_nettype wire

// ### sim/bttd_front_model.sv
// Behavioural model of the sensing front end: one tick snapshot per scan
`timescale 1ns/1ps
`default_nettype none
module bttd_front_model
   import bttd_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic scan_go,
   input wire bttd_tick_vec_type tick_in,
   output logic scan_strobe,
   output wire bttd_tick_vec_type ticks
);
   // Snapshot of the scan in flight
   bttd_tick_vec_type held;
   ////////////////////////////////////////////////////////////////////////////
   // Latch the request and pulse the strobe for one cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scan_strobe <= 1'b0;
         held <= '0;
      end else begin
         scan_strobe <= scan_go;
         // New values only when the bench asks for a scan
         if (scan_go) begin
            held <= tick_in;
         end
      end
   end
   // Ticks are valid only with the strobe; elsewhere garbage, so a late sample shows up
   assign ticks = scan_strobe ? held : ~held;
endmodule
`default_nettype wire

// ### sim/touch_button_decision_tb.sv
// Self-checking bench of the touch button decision block
`timescale 1ns/1ps
`default_nettype none
module touch_button_decision_tb;
   import bttd_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, scan_go, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic scan_strobe, comp_request, event_irq_n;
   logic [NUM_CH-1:0] touch_state, avg_suspend;
   bttd_tick_vec_type tick_in, ticks, tv;
   logic [32:0] exp_q[$]; // Expected {pslverr, prdata}, one note per transfer
   int n_mismatch = 0, samples_checked = 0, n_comp = 0, cycles = 0;
   int seed, c, n, i;
   ////////////////////////////////////////////////////////////////////////////
   // Short second (100 cycles) keeps the stuck timer test brief
   bttd_top #(.SEC_CYCLES(100)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scan_strobe(scan_strobe), .ticks(ticks),
      .touch_state(touch_state), .avg_suspend(avg_suspend), .comp_request(comp_request),
      .event_irq_n(event_irq_n));
   bttd_front_model front (.pclk(pclk), .presetn(presetn), .scan_go(scan_go),
      .tick_in(tick_in), .scan_strobe(scan_strobe), .ticks(ticks));
   // Clock at 200 MHz
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Comparison with count and report
   task automatic check(input logic [32:0] got, input logic [32:0] want);
      samples_checked++;
      if (got !== want) begin
         n_mismatch++;
         $display("MISMATCH at %0t: got %h want %h", $time, got, want);
      end
   endtask
   // Verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Watcher: each completed transfer meets the oldest note; comp pulses counted
   always @(posedge pclk) begin
      cycles++;
      if (comp_request === 1'b1) begin
         n_comp++;
      end
      if (pready === 1'b1) begin
         check({pslverr, prdata}, exp_q.pop_front());
      end
      // Ceiling well above the ~2500 cycles the tests need
      if (cycles == 20000) begin
         n_mismatch++;
         summarize();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                      input logic [32:0] want);
      exp_q.push_back(want);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d, 33'h0_0000_0000);
   endtask
   task automatic rd(input logic [5:0] idx, input logic [11:0] v);
      apb(1'b0, idx, 8'h00, {21'h00_0000, v});
   endtask
   // Random idle noise on every channel, one channel set to v
   function automatic bttd_tick_vec_type one(input int ch, input int v);
      bttd_tick_vec_type t;
      for (int k = 0; k < NUM_CH; k++) t[k] = bttd_tick_type'($random(seed) % 8);
      t[ch] = bttd_tick_type'(v);
      return t;
   endfunction
   // One scan; waiting 30 cycles keeps scans beyond the 24-cycle walk
   task automatic scan(input bttd_tick_vec_type t);
      tick_in <= t;
      scan_go <= 1'b1;
      @(posedge pclk);
      scan_go <= 1'b0;
      repeat (30) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 32'h3e05;
      {presetn, psel, penable, pwrite, scan_go, paddr, pwdata} = '0;
      tick_in = '0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, read-back of random data, unmapped index
      rd(IDX_CFG, 12'h030);
      rd(IDX_AVG, 12'h050);
      rd(IDX_NEG, 12'h0a0);
      rd(IDX_NCNT, 12'h001);
      rd(IDX_HYST, 12'h00a);
      rd(IDX_STUCK, 12'h000);
      n = $random(seed);
      wr(IDX_AVG, n[7:0]);
      rd(IDX_AVG, {4'h0, n[7:0]});
      wr(IDX_AVG, 8'h50);
      apb(1'b1, 6'h20, 8'h5a, 33'h1_0000_0000);
      apb(1'b0, 6'h20, 8'h00, 33'h1_0000_0000);
      // Status word is read-only: a write leaves it untouched
      wr(IDX_STATUS, 8'hff);
      rd(IDX_STATUS, 12'h000);
      // Threshold 128, 10 percent: touch above 140, release below 116
      scan(one(0, 140));
      rd(IDX_STATUS, 12'h000);
      scan(one(0, 141));
      rd(IDX_STATUS, 12'h001);
      scan(one(0, 116));
      rd(IDX_STATUS, 12'h001);
      scan(one(0, 115));
      rd(IDX_STATUS, 12'h000);
      // Every interrupt event selection
      for (i = 0; i < 4; i++) begin
         wr(IDX_CFG, {2'b00, i[1:0], 4'h0});
         rd(IDX_STATUS, 12'h000);
         scan(one(0, 300));
         check(33'(event_irq_n), 33'(!i[0]));
         rd(IDX_STATUS, 12'h001);
         scan(one(0, 0));
         check(33'(event_irq_n), 33'(!i[1]));
      end
      // Every debounce code for touch and release
      for (n = 0; n < 4; n++) begin
         wr(IDX_CFG, {4'h3, n[1:0], n[1:0]});
         repeat (n) scan(one(0, 300));
         rd(IDX_STATUS, 12'h000);
         scan(one(0, 300));
         rd(IDX_STATUS, 12'h001);
         repeat (n) scan(one(0, 0));
         rd(IDX_STATUS, 12'h001);
         scan(one(0, 0));
         rd(IDX_STATUS, 12'h000);
      end
      // A failed sample restarts the four-sample count
      repeat (2) scan(one(0, 300));
      scan(one(0, 0));
      repeat (3) scan(one(0, 300));
      rd(IDX_STATUS, 12'h000);
      scan(one(0, 300));
      rd(IDX_STATUS, 12'h001);
      wr(IDX_CFG, 8'h30);
      scan(one(0, 0));
      // Own threshold 256 on channel 5: touch above 281
      wr(IDX_THR0 + 6'h05, 8'h40);
      scan(one(5, 281));
      rd(IDX_STATUS, 12'h000);
      scan(one(5, 282));
      rd(IDX_STATUS, 12'h020);
      scan(one(5, 0));
      rd(IDX_THR0 + 6'h05, 12'h040);
      // Hysteresis 50 percent on threshold 128: touch above 192
      wr(IDX_HYST, 8'h32);
      rd(IDX_HYST, 12'h032);
      scan(one(0, 192));
      rd(IDX_STATUS, 12'h000);
      scan(one(0, 193));
      rd(IDX_STATUS, 12'h001);
      scan(one(0, 0));
      // Matrix, priority and single reporting
      tv = one(0, 300);
      tv[1] = tv[0];
      tv[11] = tv[0];
      scan(tv);
      rd(IDX_STATUS, 12'h001);
      wr(IDX_CFG, 8'h70);
      scan(tv);
      rd(IDX_STATUS, 12'h801);
      scan(one(0, 0));
      wr(IDX_CFG, 8'hf0);
      scan(tv);
      rd(IDX_STATUS, 12'h001);
      wr(IDX_CFG, 8'h30);
      scan(one(0, 0));
      // Averaging suspend above 320, three channels start compensation
      c = n_comp;
      tv = one(0, 321);
      tv[1] = tv[0];
      tv[2] = tv[0] - 12'h001;
      scan(tv);
      check(33'(avg_suspend), 33'h0_0000_0003);
      check(33'(n_comp - c), 33'h0_0000_0000);
      tv[2] = tv[0];
      scan(tv);
      check(33'(avg_suspend), 33'h0_0000_0007);
      check(33'(n_comp - c), 33'h0_0000_0001);
      // Negative limit -640, count limits 1 and 2
      wr(IDX_NCNT, 8'h01);
      scan(one(0, 0));
      c = n_comp;
      scan(one(4, -640));
      check(33'(n_comp - c), 33'h0_0000_0000);
      scan(one(4, -641));
      check(33'(n_comp - c), 33'h0_0000_0001);
      wr(IDX_NCNT, 8'h02);
      scan(one(4, -641));
      check(33'(n_comp - c), 33'h0_0000_0001);
      scan(one(4, -641));
      check(33'(n_comp - c), 33'h0_0000_0002);
      // Stuck touch of one second: forced release, then normal touch after lift
      scan(one(0, 0));
      wr(IDX_STUCK, 8'h01);
      c = n_comp;
      scan(one(0, 300));
      rd(IDX_STATUS, 12'h001);
      repeat (5) scan(one(0, 300));
      rd(IDX_STATUS, 12'h000);
      check(33'(n_comp - c), 33'h0_0000_0001);
      scan(one(0, 0));
      scan(one(0, 300));
      rd(IDX_STATUS, 12'h001);
      summarize();
   end
endmodule
`default_nettype wire
